/* verilog/mmdec_decoder.sv */
// Summary of operation
// - lowest 96 kB is a window showing flash or sram per remap bit.
// - top 4 kB of address space routes to peripheral registers.
// - 6 kB sram, 1536 words of 32 bits, at 0x40000.
// - access outside every defined region returns a data abort.
// - all memories little endian, low byte at lowest address.
// - sram takes byte, halfword and word accesses, writing only addressed bytes.
// - sram is one full 32-bit array, no wait cycles on word fetches.
// - vectors at 0x00-0x20 come from whichever memory fills the window.
// - after reset flash appears at address zero.
// - remap register bit 0 set maps sram to zero, cleared maps flash.
// - every reset clears the remap bit.
// - reset starts in hidden kernel which then jumps to address zero.
// - the 2 kB kernel part of flash is not reachable by user code.
// - remap register is 8 bits, read/write, reset 0x00.
// - flash also sits at 0x80000, reachable whether mirrored or not.
// - flash reads any size; writes accepted only as halfwords.
module mmdec_decoder (
  // clock and reset
  input wire logic mclk_i,
  input wire logic rst_n_i,
  // core request
  input wire logic req_i,
  input wire logic we_i,
  input wire logic [1:0] size_i,
  input wire logic [31:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic kernel_mode_i,
  // core answer
  output logic ack_o,
  output logic abort_o,
  output logic [31:0] rdata_o,
  // flash port
  output logic flash_req_o,
  output logic flash_we_o,
  output logic [16:0] flash_addr_o,
  output logic [1:0] flash_size_o,
  output logic [31:0] flash_wdata_o,
  input wire logic [31:0] flash_rdata_i,
  // peripheral register port
  output logic mpr_req_o,
  output logic mpr_we_o,
  output logic [11:0] mpr_addr_o,
  output logic [1:0] mpr_size_o,
  output logic [31:0] mpr_wdata_o,
  input wire logic [31:0] mpr_rdata_i,
  // remap state
  output logic remap_sram_o
);

  logic [7:0] memory_remap_control;
  mmdec_pkg::mmdec_target_t target;
  mmdec_pkg::mmdec_target_t rtarget;
  logic [31:0] off;
  logic aligned;
  logic [3:0] be;
  logic [31:0] wlane;
  logic sram_en;
  logic [10:0] sram_word;
  logic [31:0] sram_rdata;
  logic [1:0] rlane;
  logic [1:0] rsize;
  logic [31:0] rword;
  logic [31:0] next_rdata;

  // ---------------------------------------------------------------
  // address decode
  // ---------------------------------------------------------------
  always_comb begin
    target = mmdec_pkg::MMDEC_T_NONE;
    off = 32'h0;
    if (addr_i < mmdec_pkg::REMAP_SIZE) begin
      // vectors live here, so they follow the remap bit
      if (memory_remap_control[mmdec_pkg::REMAP_SRAM_BIT]) begin
        if (addr_i < mmdec_pkg::SRAM_SIZE) begin
          target = mmdec_pkg::MMDEC_T_SRAM;
          off = addr_i;
        end
      end else if (addr_i < mmdec_pkg::FLASH_USER_SIZE) begin
        target = mmdec_pkg::MMDEC_T_FLASH;
        off = addr_i;
      end
    end else if (addr_i >= mmdec_pkg::SRAM_BASE &&
                 addr_i < mmdec_pkg::SRAM_BASE + mmdec_pkg::SRAM_SIZE) begin
      target = mmdec_pkg::MMDEC_T_SRAM;
      off = addr_i - mmdec_pkg::SRAM_BASE;
    end else if (addr_i >= mmdec_pkg::FLASH_BASE &&
                 addr_i < mmdec_pkg::FLASH_BASE + mmdec_pkg::FLASH_SIZE) begin
      // kernel area only for the hidden start-up code
      if (addr_i < mmdec_pkg::KERNEL_BASE || kernel_mode_i) begin
        target = mmdec_pkg::MMDEC_T_FLASH;
        off = addr_i - mmdec_pkg::FLASH_BASE;
      end
    end else if ((addr_i & 32'hffff_fffc) == mmdec_pkg::MEMORY_REMAP_CONTROL_ADDR) begin
      target = mmdec_pkg::MMDEC_T_CTRL;
    end else if (addr_i >= mmdec_pkg::MPR_BASE) begin
      target = mmdec_pkg::MMDEC_T_MPR;
      off = addr_i - mmdec_pkg::MPR_BASE;
    end
  end

  // misaligned accesses are undefined too
  always_comb begin
    case (size_i)
      mmdec_pkg::SIZE_BYTE: aligned = 1'b1;
      mmdec_pkg::SIZE_HALF: aligned = ~addr_i[0];
      mmdec_pkg::SIZE_WORD: aligned = (addr_i[1:0] == 2'h0);
      default: aligned = 1'b0;
    endcase
  end

  // little-endian lanes: byte n of the word is address offset n
  always_comb begin
    case (size_i)
      mmdec_pkg::SIZE_BYTE: begin
        be = 4'h1 << addr_i[1:0];
        wlane = {4{wdata_i[7:0]}};
      end
      mmdec_pkg::SIZE_HALF: begin
        be = addr_i[1] ? 4'hc : 4'h3;
        wlane = {2{wdata_i[15:0]}};
      end
      default: begin
        be = 4'hf;
        wlane = wdata_i;
      end
    endcase
  end

  // ---------------------------------------------------------------
  // routing
  // ---------------------------------------------------------------
  logic bad;
  always_comb begin
    bad = (target == mmdec_pkg::MMDEC_T_NONE) || !aligned;
    // flash programming only in halfword units
    if (target == mmdec_pkg::MMDEC_T_FLASH && we_i && size_i != mmdec_pkg::SIZE_HALF) begin
      bad = 1'b1;
    end
  end

  assign sram_en = req_i && !bad && target == mmdec_pkg::MMDEC_T_SRAM;
  assign sram_word = off[12:2];
  assign flash_req_o = req_i && !bad && target == mmdec_pkg::MMDEC_T_FLASH;
  assign flash_we_o = we_i;
  assign flash_addr_o = off[16:0];
  assign flash_size_o = size_i;
  assign flash_wdata_o = wlane;
  assign mpr_req_o = req_i && !bad && target == mmdec_pkg::MMDEC_T_MPR;
  assign mpr_we_o = we_i;
  assign mpr_addr_o = off[11:0];
  assign mpr_size_o = size_i;
  assign mpr_wdata_o = wlane;

  mmdec_sram u_sram (
    .mclk_i(mclk_i),
    .en_i(sram_en),
    .we_i(we_i),
    .word_i(sram_word),
    .be_i(be),
    .wdata_i(wlane),
    .rdata_o(sram_rdata)
  );

  // ---------------------------------------------------------------
  // remap control register
  // ---------------------------------------------------------------
  // written at the clock edge that ends the write, so the decode above
  // only changes for the following access
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      memory_remap_control <= mmdec_pkg::MEMORY_REMAP_CONTROL_RESET;
    end else if (req_i && we_i && !bad && target == mmdec_pkg::MMDEC_T_CTRL &&
                 be[0]) begin
      // reserved bits are stored as written; software keeps them zero
      memory_remap_control <= wlane[7:0];
    end
  end

  assign remap_sram_o = memory_remap_control[mmdec_pkg::REMAP_SRAM_BIT];

  // ---------------------------------------------------------------
  // answer, one cycle after the request
  // ---------------------------------------------------------------
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ack_o <= 1'b0;
      abort_o <= 1'b0;
      rtarget <= mmdec_pkg::MMDEC_T_NONE;
      rlane <= 2'h0;
      rsize <= mmdec_pkg::SIZE_BYTE;
    end else begin
      ack_o <= req_i && !bad;
      abort_o <= req_i && bad;
      rtarget <= (req_i && !bad && !we_i) ? target : mmdec_pkg::MMDEC_T_NONE;
      rlane <= addr_i[1:0];
      rsize <= size_i;
    end
  end

  // flash and registers answer combinationally in the request cycle, so
  // their data is caught here; sram data arrives from its own flop
  logic [31:0] cap_rdata;
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cap_rdata <= 32'h0;
    end else if (req_i && !we_i) begin
      if (target == mmdec_pkg::MMDEC_T_FLASH) begin
        cap_rdata <= flash_rdata_i;
      end else if (target == mmdec_pkg::MMDEC_T_MPR) begin
        cap_rdata <= mpr_rdata_i;
      end else begin
        cap_rdata <= {24'h0, memory_remap_control};
      end
    end
  end

  always_comb begin
    case (rtarget)
      mmdec_pkg::MMDEC_T_SRAM: rword = sram_rdata;
      mmdec_pkg::MMDEC_T_FLASH, mmdec_pkg::MMDEC_T_MPR, mmdec_pkg::MMDEC_T_CTRL: rword = cap_rdata;
      default: rword = 32'h0;
    endcase
    // narrow reads come back right aligned
    case (rsize)
      mmdec_pkg::SIZE_BYTE: next_rdata = {24'h0, rword[8*rlane +: 8]};
      mmdec_pkg::SIZE_HALF: next_rdata = {16'h0, rword[16*rlane[1] +: 16]};
      default: next_rdata = rword;
    endcase
  end

  assign rdata_o = next_rdata;

endmodule : mmdec_decoder

/* verilog/mmdec_pkg.sv */
package mmdec_pkg;

  // ---------------------------------------------------------------
  // address map
  // ---------------------------------------------------------------
  localparam logic [31:0] REMAP_BASE = 32'h0000_0000;
  localparam logic [31:0] REMAP_SIZE = 32'h0001_8000;   // 96 kB window
  localparam logic [31:0] SRAM_BASE = 32'h0004_0000;
  localparam logic [31:0] SRAM_SIZE = 32'h0000_1800;    // 6 kB
  localparam logic [31:0] FLASH_BASE = 32'h0008_0000;
  localparam logic [31:0] FLASH_SIZE = 32'h0001_8000;   // 96 kB
  localparam logic [31:0] FLASH_USER_SIZE = 32'h0001_7800; // 94 kB user part
  localparam logic [31:0] KERNEL_BASE = 32'h0009_7800;  // 2 kB kernel at top
  localparam logic [31:0] MPR_BASE = 32'hffff_f000;     // top 4 kB
  localparam logic [31:0] MPR_LAST = 32'hffff_ffff;

  // ---------------------------------------------------------------
  // remap control register
  // ---------------------------------------------------------------
  localparam logic [31:0] MEMORY_REMAP_CONTROL_ADDR = 32'hffff_0220;
  localparam logic [7:0] MEMORY_REMAP_CONTROL_RESET = 8'h00;
  localparam int REMAP_SRAM_BIT = 0;

  // ---------------------------------------------------------------
  // sram geometry
  // ---------------------------------------------------------------
  localparam int SRAM_WORDS = 1536;
  localparam int SRAM_AW = 11;

  // ---------------------------------------------------------------
  // access sizes and targets
  // ---------------------------------------------------------------
  localparam logic [1:0] SIZE_BYTE = 2'h0;
  localparam logic [1:0] SIZE_HALF = 2'h1;
  localparam logic [1:0] SIZE_WORD = 2'h2;

  typedef enum logic [4:0] {
    MMDEC_T_NONE = 5'h01,
    MMDEC_T_SRAM = 5'h02,
    MMDEC_T_FLASH = 5'h04,
    MMDEC_T_MPR = 5'h08,
    MMDEC_T_CTRL = 5'h10
  } mmdec_target_t;

endpackage : mmdec_pkg

/* verilog/mmdec_sram.sv */
module mmdec_sram (
  // clock
  input wire logic mclk_i,
  // access
  input wire logic en_i,
  input wire logic we_i,
  input wire logic [10:0] word_i,
  input wire logic [3:0] be_i,
  input wire logic [31:0] wdata_i,
  // read data
  output logic [31:0] rdata_o
);

  // one 32-bit word per cycle, so word fetches need no extra wait
  logic [31:0] mem [0:mmdec_pkg::SRAM_WORDS-1];

  always_ff @(posedge mclk_i) begin
    if (en_i && we_i) begin
      for (int i = 0; i < 4; i++) begin
        if (be_i[i]) begin
          mem[word_i][8*i +: 8] <= wdata_i[8*i +: 8];
        end
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (en_i && !we_i) begin
      rdata_o <= mem[word_i];
    end
  end

endmodule : mmdec_sram

/* verif/mmdec_far_model.sv */
module mmdec_far_model (
  // clock
  input wire logic mclk_i,
  // flash side
  input wire logic flash_req_i,
  input wire logic [16:0] flash_addr_i,
  output logic [31:0] flash_rdata_o,
  // register side
  input wire logic mpr_req_i,
  input wire logic [11:0] mpr_addr_i,
  output logic [31:0] mpr_rdata_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // ---------------------------------------------------------------
  // combinational slaves
  // ---------------------------------------------------------------
  logic [31:0] junk = 32'h0;
  // idle data churns so a stale word never passes for an answer
  always @(posedge mclk_i) junk <= ~junk ^ 32'h1;
  assign flash_rdata_o = flash_req_i ?
    {flash_addr_i[9:2], 8'hc3, 8'h5a, flash_addr_i[9:2] ^ 8'h81} : junk;
  assign mpr_rdata_o = mpr_req_i ? {20'h5a5a5, mpr_addr_i} : junk;
endmodule : mmdec_far_model

/* verif/mmdec_decoder_sva.sv */
module mmdec_decoder_chk (
  // watched ports
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic req_i,
  input wire logic we_i,
  input wire logic [1:0] size_i,
  input wire logic [31:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic kernel_mode_i,
  input wire logic ack_o,
  input wire logic abort_o,
  input wire logic flash_req_o,
  input wire logic [16:0] flash_addr_o,
  input wire logic mpr_req_o,
  input wire logic [11:0] mpr_addr_o,
  input wire logic remap_sram_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // ---------------------------------------------------------------
  // properties
  // ---------------------------------------------------------------
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);
  logic rd_b, in_fl, in_win, wd0;
  assign wd0 = wdata_i[0];
  assign rd_b = req_i && !we_i && size_i == mmdec_pkg::SIZE_BYTE;
  assign in_fl = addr_i >= mmdec_pkg::FLASH_BASE && addr_i < mmdec_pkg::KERNEL_BASE;
  assign in_win = addr_i < mmdec_pkg::REMAP_SIZE;
  one_answer_a: assert property (req_i |=> ack_o != abort_o)
    else $error("no single answer");
  hole_abort_a: assert property (req_i && addr_i >= mmdec_pkg::REMAP_SIZE
    && addr_i < mmdec_pkg::SRAM_BASE |=> abort_o) else $error("hole not aborted");
  top_regs_a: assert property (rd_b && addr_i >= mmdec_pkg::MPR_BASE
    |-> mpr_req_o && mpr_addr_o == addr_i[11:0]) else $error("register route");
  flash_abs_a: assert property (rd_b && in_fl
    |-> flash_req_o && flash_addr_o == addr_i[16:0]) else $error("flash route");
  flash_zero_a: assert property (rd_b && addr_i < mmdec_pkg::FLASH_USER_SIZE
    && !remap_sram_o |-> flash_req_o && flash_addr_o == addr_i[16:0]) else $error("mirror");
  win_beyond_a: assert property (req_i && in_win && remap_sram_o
    && addr_i >= mmdec_pkg::SRAM_SIZE |-> !flash_req_o ##1 abort_o) else $error("window");
  flash_wr_a: assert property (req_i && we_i && in_fl && size_i != mmdec_pkg::SIZE_HALF
    |-> !flash_req_o ##1 abort_o) else $error("flash write size");
  kernel_hide_a: assert property (req_i && !kernel_mode_i
    && addr_i >= mmdec_pkg::KERNEL_BASE && addr_i < 32'h0009_8000 |=> abort_o)
    else $error("kernel exposed");
  remap_set_a: assert property (req_i && we_i && size_i == mmdec_pkg::SIZE_BYTE
    && addr_i == mmdec_pkg::MEMORY_REMAP_CONTROL_ADDR |=> remap_sram_o == $past(wd0))
    else $error("remap write");
  cover property (req_i && in_win && remap_sram_o);
  cover property (abort_o);
  cover property (mpr_req_o);
endmodule : mmdec_decoder_chk

/* verif/test_memory_map_remap_decoder.sv */
module test_memory_map_remap_decoder;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk_i = 0, rst_n_i = 0, req_i = 0, we_i = 0, kernel_mode_i = 0;
  logic [1:0] size_i = 2'h0;
  logic [31:0] addr_i = 32'h0, wdata_i = 32'h0, rdata_o, flash_rdata_i, mpr_rdata_i, fwd, mwd;
  logic ack_o, abort_o, flash_req_o, flash_we_o, mpr_req_o, mpr_we_o, remap_sram_o;
  logic [16:0] flash_addr_o;
  logic [11:0] mpr_addr_o;
  logic [1:0] flash_size_o, mpr_size_o;
  logic ak, ab, fr, mr;
  logic [31:0] rd;
  int miscompares = 0, n_tests = 0;
  localparam logic [31:0] CR = mmdec_pkg::MEMORY_REMAP_CONTROL_ADDR;
  localparam logic [1:0] B = mmdec_pkg::SIZE_BYTE, H = mmdec_pkg::SIZE_HALF;
  localparam logic [1:0] W = mmdec_pkg::SIZE_WORD;
  always #10 mclk_i = ~mclk_i;
  mmdec_decoder uut (.mclk_i, .rst_n_i, .req_i, .we_i, .size_i, .addr_i, .wdata_i,
    .kernel_mode_i, .ack_o, .abort_o, .rdata_o, .flash_req_o, .flash_we_o, .flash_addr_o,
    .flash_size_o, .flash_wdata_o(fwd), .flash_rdata_i, .mpr_req_o, .mpr_we_o, .mpr_addr_o,
    .mpr_size_o, .mpr_wdata_o(mwd), .mpr_rdata_i, .remap_sram_o);
  mmdec_far_model far (.mclk_i, .flash_req_i(flash_req_o), .flash_addr_i(flash_addr_o),
    .flash_rdata_o(flash_rdata_i), .mpr_req_i(mpr_req_o), .mpr_addr_i(mpr_addr_o),
    .mpr_rdata_o(mpr_rdata_i));
  // ---------------------------------------------------------------
  // access helpers
  // ---------------------------------------------------------------
  function automatic logic [31:0] fw(input logic [31:0] a);
    return {a[9:2], 8'hc3, 8'h5a, a[9:2] ^ 8'h81};
  endfunction : fw
  task automatic chk(input logic [31:0] s, e);
    n_tests++;
    if (s !== e) begin
      miscompares++;
      $display("[FAIL] %0t seen %h expected %h", $time, s, e);
    end
  endtask : chk
  // request stays up between calls so accesses run back to back
  task automatic acc(input logic w, input logic [1:0] z, input logic [31:0] a, d);
    @(negedge mclk_i);
    req_i = 1'b1; we_i = w; size_i = z; addr_i = a; wdata_i = d;
    #1 fr = flash_req_o;
    mr = mpr_req_o;
    @(posedge mclk_i);
    #1 ak = ack_o;
    ab = abort_o;
    rd = rdata_o;
  endtask : acc
  task automatic ok(input logic w, input logic [1:0] z, input logic [31:0] a, d, e);
    acc(w, z, a, d);
    chk({30'h0, ab, ak}, 32'h1);
    if (!w) chk(rd, e);
  endtask : ok
  task automatic bad(input logic w, input logic [1:0] z, input logic [31:0] a);
    acc(w, z, a, 32'h0);
    chk({28'h0, fr, mr, ab, ak}, 32'h2);
  endtask : bad
  task automatic idle();
    @(negedge mclk_i) req_i = 1'b0;
  endtask : idle
  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_boot();
    chk({31'h0, remap_sram_o}, 32'h0);
    ok(0, B, CR, 0, 32'h0);
    ok(0, B, 32'h0, 0, 32'h81);
    ok(0, W, 32'h1c, 0, fw(32'h1c));
    idle();
  endtask : t_boot
  task automatic t_sram();
    ok(1, W, 32'h40000, 32'h44332211, 0);
    ok(1, B, 32'h40001, 32'haa, 0);
    ok(1, H, 32'h40002, 32'hbbcc, 0);
    ok(0, W, 32'h40000, 0, 32'hbbccaa11);
    ok(0, B, 32'h40003, 0, 32'hbb);
    ok(1, W, 32'h417fc, 32'h01020304, 0);
    ok(0, H, 32'h417fe, 0, 32'h0102);
    idle();
  endtask : t_sram
  task automatic t_flash();
    ok(0, W, 32'h80010, 0, fw(32'h10));
    ok(0, H, 32'h80012, 0, fw(32'h10) >> 16);
    ok(0, B, 32'h80011, 0, 32'h5a);
    bad(1, W, 32'h80010);
    ok(1, H, 32'h80010, 32'h1234, 0);
    chk({31'h0, fr}, 32'h1);
    chk(fwd, 32'h12341234);
    chk({29'h0, flash_we_o, flash_size_o}, {29'h0, 1'b1, H});
    chk({15'h0, flash_addr_o}, 32'h10);
    bad(0, W, 32'h97800);
    bad(0, W, 32'h17800);
    idle();
    kernel_mode_i = 1'b1;
    ok(0, W, 32'h97800, 0, fw(32'h97800));
    idle();
    kernel_mode_i = 1'b0;
  endtask : t_flash
  task automatic t_remap();
    ok(0, W, 32'h80004, 0, fw(32'h4)); // running from absolute flash before remap
    ok(1, B, CR, 32'h01, 0); // reserved bits written as zero
    ok(0, W, 32'h0, 0, 32'hbbccaa11);
    ok(0, W, 32'h80000, 0, fw(32'h0));
    bad(0, B, 32'h1800);
    ok(0, B, CR, 0, 32'h01);
    ok(1, B, CR, 32'h00, 0);
    ok(0, W, 32'h0, 0, fw(32'h0));
    ok(1, B, CR, 32'h01, 0);
    idle();
    rst_n_i = 1'b0;
    repeat (2) @(negedge mclk_i);
    chk({31'h0, remap_sram_o}, 32'h0);
    rst_n_i = 1'b1;
    ok(0, W, 32'h0, 0, fw(32'h0));
    idle();
  endtask : t_remap
  task automatic t_map();
    bad(0, W, 32'h20000);
    bad(1, B, 32'h41800);
    ok(0, W, 32'hfffff004, 0, 32'h5a5a5004);
    chk({31'h0, mr}, 32'h1);
    ok(0, B, 32'hfffff005, 0, 32'h50);
    ok(1, H, 32'hfffff006, 32'h5678, 0);
    chk({31'h0, mr}, 32'h1);
    chk(mwd, 32'h56785678);
    chk({29'h0, mpr_we_o, mpr_size_o}, {29'h0, 1'b1, H});
    chk({20'h0, mpr_addr_o}, 32'h6);
    idle();
  endtask : t_map
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : report_and_stop
  initial begin
    repeat (20) @(negedge mclk_i);
    rst_n_i = 1'b1;
    t_boot();
    t_sram();
    t_flash();
    t_remap();
    t_map();
    report_and_stop();
  end
endmodule : test_memory_map_remap_decoder
bind mmdec_decoder mmdec_decoder_chk chk (.mclk_i, .rst_n_i, .req_i, .we_i, .size_i, .addr_i,
  .wdata_i, .kernel_mode_i, .ack_o, .abort_o, .flash_req_o, .flash_addr_o, .mpr_req_o,
  .mpr_addr_o, .remap_sram_o);
